// [logic/crx_core_regs.sv]
// Core register space, stack, data pointer and external memory bus strobes
`timescale 1ns/1ps
module crx_core_regs
	import crx_pkg::*;
#(
	parameter logic [7:0] CAL_OFS_FACTORY = 8'h80,
	parameter logic [7:0] CAL_GAIN_FACTORY = 8'h80
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Core register access
	input wire crx_req_t cpuReq,
	input wire crx_alu_flags_t aluFlags,
	input wire logic ptrInc,
	output logic rdValid,
	output logic [7:0] rdData,
	// Core state views
	output logic [1:0] bankSel,
	output logic [23:0] dataPointer,
	output logic [7:0] stackTopPointer,
	output logic baudDoubler,
	output logic fullHaltRequest,
	output logic lightSleepRequest,
	output logic [7:0] port1DigitalEn,
	output logic [7:0] calOffset,
	output logic [7:0] calGain,
	output logic downloadMode,
	// External bus request from the core
	input wire crx_bus_t busReq,
	output logic externalFetch,
	output logic [7:0] busReadData,
	// Pins
	input wire logic externalFetchSelect,
	input wire logic codeReadStrobeIn,
	output logic codeReadStrobeOut,
	output logic codeReadStrobeOe,
	output logic addressLatchStrobe,
	input wire logic [7:0] port0In,
	output logic [7:0] port0Out,
	output logic [7:0] port0Oe
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] ram [0:255];
	logic [7:0] stack_reg;
	logic [7:0] ptrLo_reg;
	logic [7:0] ptrHi_reg;
	logic [7:0] ptrPage_reg;
	logic [7:0] flags_reg;
	logic [7:0] power_reg;
	logic [7:0] port0_reg;
	logic [7:0] port1_reg;
	logic [7:0] operand_reg;
	logic [7:0] scratch_reg;
	logic [7:0] calOfs_reg;
	logic [7:0] calGain_reg;

	// Bit address to byte: low area above the banks, or an aligned special register
	function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
		bitByte = bitAddr[7] ? {bitAddr[7:3], 3'b000} : (BIT_AREA_BASE + {4'h0, bitAddr[6:3]});
	endfunction : bitByte

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	logic [7:0] tgt;
	logic isSfr;
	logic [7:0] sfrValue;
	logic [7:0] curByte;
	logic [7:0] wrByte;
	logic doWrite;

	always_comb
	begin
		tgt = cpuReq.addr;
		isSfr = 1'b0;
		case (cpuReq.kind)
			CRX_DIRECT: isSfr = cpuReq.addr[7];
			CRX_INDIRECT: tgt = cpuReq.addr;
			CRX_BIT:
			begin
				tgt = bitByte(cpuReq.addr);
				isSfr = cpuReq.addr[7];
			end
			CRX_WREG: tgt = {3'b000, flags_reg[FLAG_BANK_HI:FLAG_BANK_LO], cpuReq.addr[2:0]};
			CRX_PUSH: tgt = stack_reg + 8'h01;
			CRX_POP: tgt = stack_reg;
			default: tgt = cpuReq.addr;
		endcase
	end

	always_comb
	begin
		case (tgt)
			SFR_PORT0: sfrValue = port0_reg;
			SFR_STACK: sfrValue = stack_reg;
			SFR_PTR_LO: sfrValue = ptrLo_reg;
			SFR_PTR_HI: sfrValue = ptrHi_reg;
			SFR_PTR_PAGE: sfrValue = ptrPage_reg;
			SFR_POWER: sfrValue = power_reg & POWER_WMASK;
			SFR_PORT1: sfrValue = port1_reg;
			SFR_FLAGS: sfrValue = {flags_reg[7:1], ^operand_reg};
			SFR_OPERAND: sfrValue = operand_reg;
			SFR_SCRATCH: sfrValue = scratch_reg;
			SFR_CAL_OFS: sfrValue = calOfs_reg;
			SFR_CAL_GAIN: sfrValue = calGain_reg;
			default: sfrValue = UNMAPPED_VALUE;
		endcase
	end

	always_comb
	begin
		curByte = isSfr ? sfrValue : ram[tgt];
		wrByte = cpuReq.wdata;
		if (cpuReq.kind == CRX_BIT)
		begin
			wrByte = curByte;
			wrByte[cpuReq.addr[2:0]] = cpuReq.wdata[0];
		end
		doWrite = cpuReq.valid & ((cpuReq.write & (cpuReq.kind != CRX_POP)) | (cpuReq.kind == CRX_PUSH));
	end

	// ----------------------------------------
	// Internal data memory
	// ----------------------------------------
	always_ff @(posedge mclk)
	begin
		if (doWrite && !isSfr)
			ram[tgt] <= wrByte;
	end

	// ----------------------------------------
	// Stack pointer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			stack_reg <= STACK_RESET;
		else if (cpuReq.valid && cpuReq.kind == CRX_PUSH)
			stack_reg <= stack_reg + 8'h01;
		else if (cpuReq.valid && cpuReq.kind == CRX_POP)
			stack_reg <= stack_reg - 8'h01;
		else if (doWrite && isSfr && tgt == SFR_STACK)
			stack_reg <= wrByte;
	end

	// ----------------------------------------
	// Data pointer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ptrLo_reg <= BYTE_RESET;
			ptrHi_reg <= BYTE_RESET;
			ptrPage_reg <= BYTE_RESET;
		end
		else if (ptrInc)
			// Carry ripples into the page byte
			{ptrPage_reg, ptrHi_reg, ptrLo_reg} <= {ptrPage_reg, ptrHi_reg, ptrLo_reg} + 24'h000001;
		else if (doWrite && isSfr)
		begin
			if (tgt == SFR_PTR_LO)
				ptrLo_reg <= wrByte;
			if (tgt == SFR_PTR_HI)
				ptrHi_reg <= wrByte;
			if (tgt == SFR_PTR_PAGE)
				ptrPage_reg <= wrByte;
		end
	end

	// ----------------------------------------
	// Flag word
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			flags_reg <= FLAGS_RESET;
		else if (doWrite && isSfr && tgt == SFR_FLAGS)
			flags_reg <= wrByte;
		else if (aluFlags.update)
		begin
			flags_reg[FLAG_CARRY] <= aluFlags.carry;
			flags_reg[FLAG_AUX] <= aluFlags.aux;
			flags_reg[FLAG_OVERFLOW] <= aluFlags.overflow;
		end
	end

	// ----------------------------------------
	// Power control and plain byte registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			power_reg <= POWER_RESET;
		else if (doWrite && isSfr && tgt == SFR_POWER && cpuReq.kind == CRX_DIRECT)
			// Byte writes only; reserved bits stay zero
			power_reg <= wrByte & POWER_WMASK;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			port0_reg <= PORT_RESET;
			port1_reg <= PORT_RESET;
			port1DigitalEn <= ~PORT_RESET;
			operand_reg <= BYTE_RESET;
			scratch_reg <= BYTE_RESET;
			calOfs_reg <= CAL_OFS_FACTORY;
			calGain_reg <= CAL_GAIN_FACTORY;
		end
		else if (doWrite && isSfr)
		begin
			if (tgt == SFR_PORT0)
				port0_reg <= wrByte;
			if (tgt == SFR_PORT1)
			begin
				port1_reg <= wrByte;
				port1DigitalEn <= ~wrByte;
			end
			if (tgt == SFR_OPERAND)
				operand_reg <= wrByte;
			if (tgt == SFR_SCRATCH)
				scratch_reg <= wrByte;
			if (tgt == SFR_CAL_OFS)
				calOfs_reg <= wrByte;
			if (tgt == SFR_CAL_GAIN)
				calGain_reg <= wrByte;
		end
	end

	// ----------------------------------------
	// Read return
	// ----------------------------------------
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdValid <= 1'b0;
			rdData <= BYTE_RESET;
		end
		else
		begin
			rdValid <= cpuReq.valid & (!cpuReq.write | (cpuReq.kind == CRX_POP)) & (cpuReq.kind != CRX_PUSH);
			rdData <= (cpuReq.kind == CRX_BIT) ? {7'h00, curByte[cpuReq.addr[2:0]]} : curByte;
		end
	end

	// ----------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------
	logic [2:0] selSync_reg;
	logic [2:0] strapSync_reg;
	logic [7:0] p0Sync1_reg;
	logic [7:0] p0Sync2_reg;
	logic [7:0] p0Sync3_reg;
	logic fetchSel_reg;
	logic [2:0] strapCnt_reg;
	logic strapDone_reg;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			selSync_reg <= 3'h0;
			strapSync_reg <= 3'h7;
			p0Sync1_reg <= BYTE_RESET;
			p0Sync2_reg <= BYTE_RESET;
			p0Sync3_reg <= BYTE_RESET;
			fetchSel_reg <= 1'b0;
		end
		else
		begin
			selSync_reg <= {selSync_reg[1:0], externalFetchSelect};
			strapSync_reg <= {strapSync_reg[1:0], codeReadStrobeIn};
			p0Sync1_reg <= port0In;
			p0Sync2_reg <= p0Sync1_reg;
			p0Sync3_reg <= p0Sync2_reg;
			if (selSync_reg[1] == selSync_reg[2])
				fetchSel_reg <= selSync_reg[2];
		end
	end

	// Pin is released after reset so an external pull-down can win before sampling
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			strapCnt_reg <= 3'h0;
			strapDone_reg <= 1'b0;
			downloadMode <= 1'b0;
		end
		else if (!strapDone_reg)
		begin
			strapCnt_reg <= strapCnt_reg + 3'h1;
			if (strapCnt_reg == STRAP_WAIT && strapSync_reg[1] == strapSync_reg[2])
			begin
				strapDone_reg <= 1'b1;
				downloadMode <= ~strapSync_reg[2];
			end
			else if (strapCnt_reg == STRAP_WAIT)
				strapCnt_reg <= strapCnt_reg;
		end
	end

	// ----------------------------------------
	// External bus timing
	// ----------------------------------------
	logic [2:0] phase_reg;
	logic capPending_reg;
	logic extFetchNow;
	logic busActive;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			phase_reg <= 3'h0;
		else if (phase_reg == MACHINE_PHASES - 3'h1)
			phase_reg <= 3'h0;
		else
			phase_reg <= phase_reg + 3'h1;
	end

	always_comb
	begin
		// Internal range only when select is high
		extFetchNow = busReq.fetchReq & (!fetchSel_reg | (busReq.pcAddr > INT_CODE_TOP));
		busActive = (extFetchNow | busReq.dataAccess) & strapDone_reg;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addressLatchStrobe <= 1'b0;
			codeReadStrobeOut <= 1'b1;
			codeReadStrobeOe <= 1'b0;
			externalFetch <= 1'b0;
			port0Out <= BYTE_RESET;
			port0Oe <= BYTE_RESET;
			busReadData <= BYTE_RESET;
			capPending_reg <= 1'b0;
		end
		else
		begin
			externalFetch <= extFetchNow;
			codeReadStrobeOe <= strapDone_reg;
			// Latch strobe each machine slot, not in data access or while the latch-off power bit is set
			addressLatchStrobe <= (phase_reg == 3'h0) & !busReq.dataAccess & !power_reg[PWR_LATCH_OFF]
				& strapDone_reg;
			// Read strobe low only for external fetch
			codeReadStrobeOut <= !((phase_reg >= 3'h1) & (phase_reg <= 3'h4) & extFetchNow
				& !busReq.dataAccess & strapDone_reg);
			if (busActive && phase_reg <= 3'h1)
			begin
				port0Out <= busReq.dataAccess ? ptrLo_reg : busReq.pcAddr[7:0];
				port0Oe <= 8'hFF;
			end
			else if (busActive && busReq.dataAccess && busReq.dataWrite)
			begin
				port0Out <= busReq.dataOut;
				port0Oe <= 8'hFF;
			end
			else if (busActive)
			begin
				port0Out <= BYTE_RESET;
				port0Oe <= BYTE_RESET;
			end
			else
			begin
				// Written ones float, zeros pull low
				port0Out <= BYTE_RESET;
				port0Oe <= ~port0_reg;
			end
			// Sync delay: memory data reaches the third stage as the slot ends and is captured one cycle later
			capPending_reg <= busActive && phase_reg == MACHINE_PHASES - 3'h1;
			if (capPending_reg)
				busReadData <= p0Sync3_reg;
		end
	end

	// ----------------------------------------
	// State views
	// ----------------------------------------
	// Bank from flag bits 4 and 3
	assign bankSel = flags_reg[FLAG_BANK_HI:FLAG_BANK_LO];
	assign dataPointer = {ptrPage_reg, ptrHi_reg, ptrLo_reg};
	assign stackTopPointer = stack_reg;
	assign baudDoubler = power_reg[PWR_BAUD_DOUBLER];
	assign fullHaltRequest = power_reg[PWR_FULL_HALT];
	assign lightSleepRequest = power_reg[PWR_LIGHT_SLEEP];
	assign calOffset = calOfs_reg;
	assign calGain = calGain_reg;

endmodule : crx_core_regs

// [logic/crx_pkg.sv]
// Shared constants and types for the core register bank and external bus strobes
package crx_pkg;

	// ----------------------------------------
	// Special register offsets
	// ----------------------------------------
	localparam logic [7:0] SFR_PORT0 = 8'h80;
	localparam logic [7:0] SFR_STACK = 8'h81;
	localparam logic [7:0] SFR_PTR_LO = 8'h82;
	localparam logic [7:0] SFR_PTR_HI = 8'h83;
	localparam logic [7:0] SFR_PTR_PAGE = 8'h84;
	localparam logic [7:0] SFR_POWER = 8'h87;
	localparam logic [7:0] SFR_PORT1 = 8'h90;
	localparam logic [7:0] SFR_FLAGS = 8'hD0;
	localparam logic [7:0] SFR_OPERAND = 8'hE0;
	localparam logic [7:0] SFR_SCRATCH = 8'hF0;
	localparam logic [7:0] SFR_CAL_OFS = 8'hF1;
	localparam logic [7:0] SFR_CAL_GAIN = 8'hF2;

	// ----------------------------------------
	// Data memory layout
	// ----------------------------------------
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
	localparam logic [15:0] INT_CODE_TOP = 16'h1FFF;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] STACK_RESET = 8'h07;
	localparam logic [7:0] POWER_RESET = 8'h00;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FLAG_CARRY = 7;
	localparam int FLAG_AUX = 6;
	localparam int FLAG_BANK_HI = 4;
	localparam int FLAG_BANK_LO = 3;
	localparam int FLAG_OVERFLOW = 2;
	localparam int FLAG_PARITY = 0;
	localparam int PWR_BAUD_DOUBLER = 7;
	localparam int PWR_LATCH_OFF = 4;
	localparam int PWR_FULL_HALT = 1;
	localparam int PWR_LIGHT_SLEEP = 0;
	localparam logic [7:0] POWER_WMASK = 8'h9F;

	// ----------------------------------------
	// Timing counts
	// ----------------------------------------
	localparam logic [2:0] MACHINE_PHASES = 3'h6;
	localparam logic [2:0] STRAP_WAIT = 3'h5;

	typedef enum logic [2:0] {CRX_DIRECT, CRX_INDIRECT, CRX_BIT, CRX_WREG, CRX_PUSH, CRX_POP} crx_kind_t;

	typedef struct packed {
		logic valid;
		logic write;
		crx_kind_t kind;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crx_req_t;

	typedef struct packed {
		logic update;
		logic carry;
		logic aux;
		logic overflow;
	} crx_alu_flags_t;

	typedef struct packed {
		logic fetchReq;
		logic [15:0] pcAddr;
		logic dataAccess;
		logic dataWrite;
		logic [7:0] dataOut;
	} crx_bus_t;

endpackage : crx_pkg

// [tb/core_registers_extbus_ctrl_test.sv]
// Self-checking bench for the core register bank and bus strobes
`timescale 1ns/1ps
module core_registers_extbus_ctrl_test
	import crx_pkg::*;
;
	logic mclk = 1'b0;
	logic reset_n;
	crx_req_t cpuReq;
	crx_alu_flags_t aluFlags;
	logic ptrInc;
	crx_bus_t busReq;
	logic externalFetchSelect;
	logic strapLevel;
	logic rdValid, baudDoubler, fullHaltRequest, lightSleepRequest, downloadMode, externalFetch;
	logic codeReadStrobeOut, codeReadStrobeOe, addressLatchStrobe, strobePin;
	logic [1:0] bankSel;
	logic [23:0] dataPointer;
	logic [7:0] rdData, stackTopPointer, port1DigitalEn, calOffset, calGain, busReadData;
	logic [7:0] port0Out, port0Oe, port0Pin;
	int err_total = 0;
	int compares = 0;
	int nl, nlow;
	// rows keep clear of special locations reserved for testing
	logic [23:0] rows [9] = '{24'h813030, 24'h821111, 24'h832222, 24'h843333, 24'h87FF9F,
		24'h900000, 24'hA15500, 24'hE05A5A, 24'hD01818};

	// ---
	// Harness
	// ---
	initial forever #20 mclk = ~mclk;
	// strap resistor only wins while the strobe pin is not driven
	assign strobePin = codeReadStrobeOe ? codeReadStrobeOut : strapLevel;
	crx_core_regs #(.CAL_OFS_FACTORY(8'h3C), .CAL_GAIN_FACTORY(8'hC3)) i_dut (.*,
		.codeReadStrobeIn(strobePin), .port0In(port0Pin));
	crx_ext_mem i_mem (.*);

	// ---
	// Tasks
	// ---
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic op(input crx_kind_t k, input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		cpuReq <= '{1'b1, w, k, a, d};
		@(posedge mclk);
		cpuReq <= '0;
		#1;
	endtask : op

	task automatic rd(input crx_kind_t k, input logic [7:0] a, input logic [7:0] exp);
		op(k, 1'b0, a, 8'h00);
		chk(24'(rdValid), 24'h1);
		chk(24'(rdData), 24'(exp));
	endtask : rd

	// Counts strobes over two whole slots once the new request has settled
	task automatic slots(input crx_bus_t b, input logic sel);
		@(posedge mclk);
		busReq <= b;
		externalFetchSelect <= sel;
		nl = 0;
		nlow = 0;
		repeat (12) @(posedge mclk);
		repeat (12)
		begin
			@(posedge mclk);
			#1;
			nl += addressLatchStrobe;
			nlow += !codeReadStrobeOut;
		end
	endtask : slots

	task automatic do_reset(input logic strap);
		int n;
		@(posedge mclk);
		reset_n <= 1'b0;
		strapLevel <= strap;
		repeat (16) @(posedge mclk);
		reset_n <= 1'b1;
		n = 0;
		while (codeReadStrobeOe !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 40)
		begin
			err_total++;
			wrap_up();
		end
	endtask : do_reset

	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// ---
	// Sequence
	// ---
	initial
	begin
		reset_n = 1'b0;
		cpuReq = '0;
		aluFlags = '0;
		ptrInc = 1'b0;
		busReq = '0;
		externalFetchSelect = 1'b1;
		strapLevel = 1'b1;
		do_reset(1'b1);
		chk(24'(downloadMode), 24'h0);
		foreach (rows[i])
		begin
			op(CRX_DIRECT, 1'b1, rows[i][23:16], rows[i][15:8]);
			rd(CRX_DIRECT, rows[i][23:16], rows[i][7:0]);
		end
		chk(24'(bankSel), 24'h3);
		chk(24'(port1DigitalEn), 24'hFF);
		chk(dataPointer, 24'h332211);
		chk({21'h0, baudDoubler, fullHaltRequest, lightSleepRequest}, 24'h7);
		$display("test table done");
		slots('{1'b1, 16'h2034, 1'b0, 1'b0, 8'h00}, 1'b1);
		chk(24'(nl), 24'h0);
		op(CRX_DIRECT, 1'b1, SFR_POWER, 8'h00);
		slots('{1'b1, 16'h2034, 1'b0, 1'b0, 8'h00}, 1'b1);
		chk(24'(nl), 24'h2);
		chk(24'(nlow), 24'h8);
		chk(24'(externalFetch), 24'h1);
		chk(24'(busReadData), 24'h6E);
		slots('{1'b1, 16'h1FFF, 1'b0, 1'b0, 8'h00}, 1'b1);
		chk(24'(nlow), 24'h0);
		slots('{1'b1, 16'h1FFF, 1'b0, 1'b0, 8'h00}, 1'b0);
		chk(24'(nlow), 24'h8);
		slots('{1'b1, 16'h1FFF, 1'b1, 1'b0, 8'h00}, 1'b0);
		chk(24'(nl), 24'h0);
		chk(24'(nlow), 24'h0);
		slots('0, 1'b1);
		op(CRX_DIRECT, 1'b1, SFR_PORT0, 8'h0F);
		@(posedge mclk);
		#1;
		chk(24'(port0Oe), 24'hF0);
		$display("test bus done");
		op(CRX_DIRECT, 1'b1, SFR_PTR_PAGE, 8'h01);
		op(CRX_DIRECT, 1'b1, SFR_PTR_HI, 8'hFF);
		op(CRX_DIRECT, 1'b1, SFR_PTR_LO, 8'hFF);
		@(posedge mclk);
		ptrInc <= 1'b1;
		@(posedge mclk);
		ptrInc <= 1'b0;
		#1;
		chk(dataPointer, 24'h020000);
		op(CRX_WREG, 1'b1, 8'h02, 8'h9C);
		rd(CRX_DIRECT, 8'h1A, 8'h9C);
		op(CRX_DIRECT, 1'b1, BIT_AREA_BASE, 8'h00);
		op(CRX_DIRECT, 1'b1, 8'h2F, 8'h00);
		op(CRX_BIT, 1'b1, 8'h05, 8'h01);
		rd(CRX_DIRECT, BIT_AREA_BASE, 8'h20);
		op(CRX_BIT, 1'b1, 8'h7F, 8'h01);
		rd(CRX_DIRECT, 8'h2F, 8'h80);
		op(CRX_INDIRECT, 1'b1, SFR_PORT1, 8'h77);
		rd(CRX_DIRECT, SFR_PORT1, 8'h00);
		rd(CRX_INDIRECT, SFR_PORT1, 8'h77);
		op(CRX_BIT, 1'b1, 8'h91, 8'h01);
		rd(CRX_DIRECT, SFR_PORT1, 8'h02);
		rd(CRX_BIT, 8'h91, 8'h01);
		@(posedge mclk);
		aluFlags <= '{1'b1, 1'b1, 1'b0, 1'b1};
		@(posedge mclk);
		aluFlags <= '0;
		op(CRX_DIRECT, 1'b1, SFR_OPERAND, 8'h01);
		rd(CRX_DIRECT, SFR_FLAGS, 8'h9D);
		$display("test memory done");
		do_reset(1'b0);
		chk(24'(downloadMode), 24'h1);
		chk(24'({calOffset, calGain}), 24'h3CC3);
		rd(CRX_DIRECT, SFR_POWER, 8'h00);
		rd(CRX_DIRECT, SFR_STACK, 8'h07);
		op(CRX_PUSH, 1'b1, 8'h00, 8'hAA);
		chk(24'(stackTopPointer), 24'h08);
		rd(CRX_INDIRECT, 8'h08, 8'hAA);
		rd(CRX_POP, 8'h00, 8'hAA);
		chk(24'(stackTopPointer), 24'h07);
		$display("test reset done");
		wrap_up();
	end

	initial
	begin
		#2000000;
		err_total++;
		wrap_up();
	end
endmodule : core_registers_extbus_ctrl_test

// [tb/crx_core_regs_asserts.sv]
// Port-level assertions for the core register bank and bus strobes
`timescale 1ns/1ps
module crx_core_regs_asserts
	import crx_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Core side
	input wire crx_req_t cpuReq,
	input wire logic ptrInc,
	input wire logic [1:0] bankSel,
	input wire logic [23:0] dataPointer,
	input wire logic [7:0] stackTopPointer,
	input wire logic baudDoubler,
	input wire logic externalFetch,
	// Pins
	input wire logic codeReadStrobeOut,
	input wire logic codeReadStrobeOe,
	input wire logic addressLatchStrobe,
	input wire logic [7:0] port0Oe
);
	// ---
	// Helpers
	// ---
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	logic dirWr;
	logic [1:0] bankNext;
	logic baudNext;
	assign dirWr = cpuReq.valid && cpuReq.write && cpuReq.kind == CRX_DIRECT;
	assign bankNext = cpuReq.wdata[4:3];
	assign baudNext = cpuReq.wdata[7];

	// ---
	// Checks
	// ---
	stack_reset_a: assert property ($rose(reset_n) |-> stackTopPointer == STACK_RESET)
		else $error("stack pointer not at its reset value");
	stack_push_a: assert property (cpuReq.valid && cpuReq.kind == CRX_PUSH
		|=> stackTopPointer == $past(stackTopPointer) + 8'h01)
		else $error("stack pointer not incremented by push");
	pointer_carry_a: assert property (ptrInc |=> dataPointer == $past(dataPointer) + 24'h000001)
		else $error("pointer increment wrong");
	bank_select_a: assert property (dirWr && cpuReq.addr == SFR_FLAGS |=> bankSel == $past(bankNext))
		else $error("bank select does not follow flag word");
	baud_bit_a: assert property (dirWr && cpuReq.addr == SFR_POWER |=> baudDoubler == $past(baudNext))
		else $error("baud doubler does not follow power control");
	// Seven cycles of internal fetch let a slot already under way finish
	strobe_internal_a: assert property ((codeReadStrobeOe && !externalFetch) [*7] |-> codeReadStrobeOut)
		else $error("code-read strobe active on internal fetch");
	strobe_width_a: assert property ($fell(codeReadStrobeOut) |-> ##4 codeReadStrobeOut)
		else $error("code-read strobe low too long");
	latch_space_a: assert property (addressLatchStrobe |=> !addressLatchStrobe [*5])
		else $error("latch strobe closer than six cycles");
	latch_drive_a: assert property (addressLatchStrobe && externalFetch |-> port0Oe == 8'hFF)
		else $error("port 0 not driving address at latch");
endmodule : crx_core_regs_asserts

bind crx_core_regs crx_core_regs_asserts i_chk (.*);

// [tb/crx_ext_mem.sv]
// External program memory model on the multiplexed port 0 bus
`timescale 1ns/1ps
module crx_ext_mem
	import crx_pkg::*;
(
	// Clock
	input wire logic mclk,
	// Strobes
	input wire logic addressLatchStrobe,
	input wire logic codeReadStrobeOut,
	// Port 0 pin
	input wire logic [7:0] port0Out,
	input wire logic [7:0] port0Oe,
	output logic [7:0] port0Pin
);
	logic [7:0] addrLow_reg;
	logic [7:0] lastPin_reg = 8'h00;

	// ---
	// Behaviour
	// ---
	// low address captured while the latch strobe is high
	always_ff @(posedge mclk)
	begin
		if (addressLatchStrobe)
		begin
			addrLow_reg <= port0Pin;
		end
	end
	// No pull-ups on port 0: a floating line shows the inverse of its last level
	always_ff @(posedge mclk)
	begin
		lastPin_reg <= port0Pin;
	end
	// memory answers only while the code-read strobe is low
	assign port0Pin = (port0Oe & port0Out)
		| (~port0Oe & (!codeReadStrobeOut ? addrLow_reg ^ 8'h5A : ~lastPin_reg));
endmodule : crx_ext_mem
